// [inc/uart_core_if.sv]
`timescale 1ns/1ps

interface uart_core_if;
  // clock source selection and divisor
  logic pin_clk;
  logic aux_clk;
  logic sub_clk;
  logic pol_invert;
  logic [1:0] src_sel;
  logic [15:0] divisor;
  logic src_tick;
  logic bit_tick;
  // receive line and framing setup
  logic rxd;
  logic char8;
  logic addr_bit_en;
  logic parity_en;
  logic parity_even;
  // one received character
  logic ch_valid;
  logic [7:0] ch_data;
  logic ch_addr;
  logic ch_frame_err;
  logic ch_parity_err;
  logic ch_break;

  modport baud (input pin_clk, aux_clk, sub_clk, pol_invert, src_sel, divisor, output src_tick, bit_tick);
  modport rx (input src_tick, divisor, rxd, char8, addr_bit_en, parity_en, parity_even,
              output ch_valid, ch_data, ch_addr, ch_frame_err, ch_parity_err, ch_break);
  modport ctrl (output pin_clk, aux_clk, sub_clk, pol_invert, src_sel, divisor, rxd, char8, addr_bit_en,
                parity_en, parity_even,
                input src_tick, bit_tick, ch_valid, ch_data, ch_addr, ch_frame_err, ch_parity_err, ch_break);
endinterface : uart_core_if

// [inc/uart_pkg.sv]
package uart_pkg;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS,
    RX_STOP
  } rx_state_t;

  typedef enum logic {
    TX_IDLE,
    TX_SHIFT
  } tx_state_t;

  typedef enum logic [3:0] {
    SEL_TCTL,
    SEL_RCTL,
    SEL_BRLO,
    SEL_BRHI,
    SEL_LCTL,
    SEL_TXBUF,
    SEL_RXBUF,
    SEL_STAT,
    SEL_NONE
  } reg_sel_t;

endpackage : uart_pkg

// [inc/uart_reg_map.svh]
`ifndef UART_REG_MAP_SVH
`define UART_REG_MAP_SVH

// register byte offsets on the apb bus
`define UART_OFS_TCTL 8'h00
`define UART_OFS_RCTL 8'h04
`define UART_OFS_BRLO 8'h08
`define UART_OFS_BRHI 8'h0C
`define UART_OFS_LCTL 8'h10
`define UART_OFS_TXBUF 8'h14
`define UART_OFS_RXBUF 8'h18
`define UART_OFS_STAT 8'h1C

// transmit_control fields
`define UART_TCTL_POL 6
`define UART_TCTL_SSEL_HI 5
`define UART_TCTL_SSEL_LO 4
`define UART_TCTL_RXSE 3
`define UART_TCTL_WAKE 2
`define UART_TCTL_EMPTY 0
`define UART_TCTL_RESET 8'h01

// receive_control fields
`define UART_RCTL_FE 7
`define UART_RCTL_PE 6
`define UART_RCTL_OE 5
`define UART_RCTL_BRK 4
`define UART_RCTL_EIE 3
`define UART_RCTL_WIE 2
`define UART_RCTL_WAKE 1
`define UART_RCTL_ERR 0
`define UART_RCTL_RESET 8'h00

// line_control fields
`define UART_LCTL_PARITY_ENABLE 7
`define UART_LCTL_PEVEN 6
`define UART_LCTL_STOP2 5
`define UART_LCTL_CHAR8 4
`define UART_LCTL_ADDRBIT 1
`define UART_LCTL_RESET 8'h10

// status fields
`define UART_STAT_RXIFG 0
`define UART_STAT_TXBUF_FREE 1

// baud divisor reset value
`define UART_BR_RESET 16'h0003

`endif

// [verif/uart_ctrl_top_chk.sv]
`timescale 1ns/1ps
`include "uart_reg_map.svh"
module uart_ctrl_top_chk (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic rxd_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic txd_o,
  input wire logic rx_start_edge_o
);
  logic [7:0] tc_r, tc_nxt, rc_r, rc_nxt, br_r, br_nxt;
  logic pe_r, pe_nxt, wr, rt, rr;
  // shadows of software writes; hardware-owned bits are masked off
  always_comb begin
    wr = psel_i && penable_i && pready_o && pwrite_i;
    tc_nxt = (wr && paddr_i == `UART_OFS_TCTL) ? pwdata_i[7:0] & 8'h78 : tc_r;
    rc_nxt = (wr && paddr_i == `UART_OFS_RCTL) ? pwdata_i[7:0] & 8'h0C : rc_r;
    br_nxt = (wr && paddr_i == `UART_OFS_BRLO) ? pwdata_i[7:0] : br_r;
    pe_nxt = (wr && paddr_i == `UART_OFS_LCTL) ? pwdata_i[`UART_LCTL_PARITY_ENABLE] : pe_r;
    rt = pready_o && !pwrite_i && paddr_i == `UART_OFS_TCTL;
    rr = pready_o && !pwrite_i && paddr_i == `UART_OFS_RCTL;
  end
  // shadow registers, reset like the device
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tc_r <= 8'h00;
      rc_r <= 8'h00;
      br_r <= 8'h03;
      pe_r <= 1'b0;
    end else begin
      tc_r <= tc_nxt;
      rc_r <= rc_nxt;
      br_r <= br_nxt;
      pe_r <= pe_nxt;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_ready_wait: assert property ($rose(penable_i) && psel_i |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after access start");
  a_start_gated: assert property (rx_start_edge_o |-> tc_r[3] || $past(tc_r[3]))
    else $error("start edge pulse while disabled");
  // two sync flops plus the registered pulse flop put the pulse three edges after the pin falls
  a_start_seen: assert property ($fell(rxd_i) && tc_r[3] |-> ##3 rx_start_edge_o)
    else $error("start edge pulse missing");
  a_empty_busy: assert property (rt && !txd_o |-> !prdata_o[0])
    else $error("empty flag set while frame on line");
  a_tctl_back: assert property (rt |-> (prdata_o[7:0] & 8'hFA) == tc_r)
    else $error("transmit control readback wrong");
  a_parity_off: assert property (rr && !pe_r |-> !prdata_o[6])
    else $error("parity flag set with parity off");
  a_err_sum: assert property (rr |-> prdata_o[0] == |prdata_o[7:4])
    else $error("summary error flag disagrees");
  a_int_en_back: assert property (rr |-> prdata_o[3:2] == rc_r[3:2])
    else $error("interrupt enables readback wrong");
  a_brlo_back: assert property (pready_o && !pwrite_i && paddr_i == `UART_OFS_BRLO |-> prdata_o == {24'h0, br_r})
    else $error("divisor low byte readback wrong");
endmodule : uart_ctrl_top_chk

bind uart_ctrl_top uart_ctrl_top_chk u_chk (.clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .rxd_i, .prdata_o, .pready_o, .txd_o, .rx_start_edge_o);

// [verif/uart_remote_node.sv]
`timescale 1ns/1ps
module uart_remote_node (
  input wire logic clk_src_i,
  input wire logic txd_i,
  output logic rxd_o
);
  // divisor stays at its reset value, never below three
  localparam int BIT_EDGES = 3;
  initial rxd_o = 1'b1;
  // start, 8 data lsb first, then a last bit (stop, parity or address) and idle high
  task automatic send(input logic [7:0] d, input logic last);
    logic [9:0] f;
    f = {last, d, 1'b0};
    @(posedge clk_src_i);
    for (int i = 0; i < 10; i++) begin
      rxd_o = f[i];
      repeat (BIT_EDGES) @(posedge clk_src_i);
    end
    rxd_o = 1'b1;
    repeat (2 * BIT_EDGES) @(posedge clk_src_i);
  endtask : send
  // samples late in each bit since the device launches bits a few cycles after its tick
  task automatic recv(output logic [7:0] d);
    @(negedge txd_i);
    repeat (BIT_EDGES + 2) @(posedge clk_src_i);
    for (int i = 0; i < 8; i++) begin
      d[i] = txd_i;
      repeat (BIT_EDGES) @(posedge clk_src_i);
    end
  endtask : recv
endmodule : uart_remote_node

// [verif/uart_tx_rx_control_status_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module uart_tx_rx_control_status_tb;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic pin_clk = 1'b0, aux_clk = 1'b0, sub_clk = 1'b0, rxd, txd, pready, pslverr, pclk, er;
  logic [7:0] paddr_i = 8'h00, tsel = 8'h00, got;
  logic [31:0] pwdata_i = 32'h0, prdata, rv;
  int error_cnt = 0, n_tests = 0;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic x;} row_t;
  // write, address, write data, expected read, expected error
  row_t rows [17] = '{'{1'b0, 8'h00, 8'h00, 8'h01, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h08, 8'h00, 8'h03, 1'b0}, '{1'b1, 8'h00, 8'hFF, 8'h00, 1'b0}, '{1'b0, 8'h00, 8'h00, 8'h7D, 1'b0},
    '{1'b1, 8'h00, 8'h20, 8'h00, 1'b0}, '{1'b0, 8'h00, 8'h00, 8'h21, 1'b0}, '{1'b1, 8'h04, 8'hFF, 8'h00, 1'b0},
    '{1'b0, 8'h04, 8'h00, 8'h0C, 1'b0}, '{1'b1, 8'h04, 8'h08, 8'h00, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'h08, 1'b0},
    '{1'b1, 8'h08, 8'hA5, 8'h00, 1'b0}, '{1'b0, 8'h08, 8'h00, 8'hA5, 1'b0}, '{1'b1, 8'h08, 8'h03, 8'h00, 1'b0},
    '{1'b0, 8'h08, 8'h00, 8'h03, 1'b0}, '{1'b0, 8'h20, 8'h00, 8'h00, 1'b1}, '{1'b1, 8'h24, 8'h55, 8'h00, 1'b1}};
  // clocks at unrelated rates, all well below a quarter of the system clock
  always #10 clk_sys_i = ~clk_sys_i;
  always #180 pin_clk = ~pin_clk;
  always #140 aux_clk = ~aux_clk;
  always #100 sub_clk = ~sub_clk;
  assign pclk = tsel[5] ? sub_clk : tsel[4] ? aux_clk : pin_clk ^ tsel[6];
  uart_ctrl_top dut (.clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .external_bitclock_pin_i(pin_clk), .aux_clock_i(aux_clk), .submain_clock_i(sub_clk), .rxd_i(rxd),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .txd_o(txd), .rx_start_edge_o());
  uart_remote_node node (.clk_src_i(pclk), .txd_i(txd), .rxd_o(rxd));
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    `CHK("apb ready", 1'b1, pready)
    rv = prdata;
    er = pslverr;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK("register read", {24'h0, e}, rv)
  endtask : rchk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // a hung handshake or frame ends the run here
  initial begin
    #400_000;
    `CHK("watchdog", 1'b0, 1'b1)
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK("apb error", rows[i].x, er)
      if (!rows[i].w) `CHK("table read", {24'h0, rows[i].e}, rv)
    end
    $display("test done: register table");
    // every source select code, then the inverted pin clock
    for (int i = 0; i < 5; i++) begin
      tsel = 8'(i * 16);
      apb(1'b1, 8'h00, tsel);
      fork
        node.recv(got);
        begin
          apb(1'b1, 8'h14, 8'h3C + 8'(i));
          rchk(8'h00, tsel);
        end
      join
      `CHK("tx byte", 8'h3C + 8'(i), got)
      rv = 32'h0;
      for (int j = 0; j < 200 && rv[0] !== 1'b1; j++) apb(1'b0, 8'h00, 8'h00);
      `CHK("tx empty", tsel | 8'h01, rv[7:0])
    end
    $display("test done: transmit and clock sources");
    tsel = 8'h28;
    apb(1'b1, 8'h00, tsel);
    node.send(8'hA5, 1'b1);
    rchk(8'h1C, 8'h03);
    rchk(8'h18, 8'hA5);
    rchk(8'h04, 8'h08);
    rchk(8'h1C, 8'h02);
    node.send(8'h00, 1'b0);
    rchk(8'h04, 8'h99);
    rchk(8'h1C, 8'h03);
    rchk(8'h18, 8'h00);
    rchk(8'h04, 8'h08);
    node.send(8'h11, 1'b1);
    node.send(8'h22, 1'b1);
    rchk(8'h04, 8'h29);
    rchk(8'h18, 8'h22);
    rchk(8'h04, 8'h08);
    $display("test done: receive errors");
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h10, 8'h90);
    node.send(8'h01, 1'b1);
    rchk(8'h04, 8'h41);
    rchk(8'h1C, 8'h02);
    rchk(8'h18, 8'h22);
    node.send(8'h01, 1'b0);
    rchk(8'h1C, 8'h03);
    rchk(8'h18, 8'h01);
    apb(1'b1, 8'h10, 8'h12);
    apb(1'b1, 8'h04, 8'h04);
    node.send(8'h55, 1'b0);
    rchk(8'h1C, 8'h02);
    node.send(8'h66, 1'b1);
    rchk(8'h04, 8'h06);
    rchk(8'h18, 8'h66);
    // seven-bit characters: the buffer msb reads zero
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h10, 8'h00);
    node.send(8'hC3, 1'b1);
    rchk(8'h18, 8'h43);
    $display("test done: parity and wake");
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    @(posedge clk_sys_i);
    `CHK("txd idle", 1'b1, txd)
    repeat (7) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rchk(8'h00, 8'h01);
    rchk(8'h04, 8'h00);
    $display("test done: second reset");
    wrap_up();
  end
endmodule : uart_tx_rx_control_status_tb

// [verilog/uart_baud_gen.sv]
`timescale 1ns/1ps

module uart_baud_gen (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  uart_core_if.baud core
);
  logic src_lvl_r, src_lvl_nxt;
  logic src_tick_r, src_tick_nxt;
  logic bit_tick_r, bit_tick_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic sel_clk;

  // pick the baud source; inputs arrive already synchronised
  always_comb begin
    sel_clk = core.sub_clk;
    if (core.src_sel == 2'h0) begin
      sel_clk = core.pin_clk ^ core.pol_invert;
    end else if (core.src_sel == 2'h1) begin
      sel_clk = core.aux_clk;
    end
    src_lvl_nxt = sel_clk;
    src_tick_nxt = sel_clk & ~src_lvl_r;
    bit_tick_nxt = 1'b0;
    cnt_nxt = cnt_r;
    // divisor below 3 gives junk timing; zero is only kept from hanging
    if (src_tick_r) begin
      if (cnt_r <= 16'h0001) begin
        cnt_nxt = core.divisor;
        bit_tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_lvl_r <= 1'b0;
      src_tick_r <= 1'b0;
      bit_tick_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else begin
      src_lvl_r <= src_lvl_nxt;
      src_tick_r <= src_tick_nxt;
      bit_tick_r <= bit_tick_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign core.src_tick = src_tick_r;
  assign core.bit_tick = bit_tick_r;
endmodule : uart_baud_gen

// [verilog/uart_ctrl_top.sv]
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "uart_reg_map.svh"

module uart_ctrl_top (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic external_bitclock_pin_i,
  input wire logic aux_clock_i,
  input wire logic submain_clock_i,
  input wire logic rxd_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic txd_o,
  output logic rx_start_edge_o
);
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [3:0] pin_meta_r, pin_sync_r;
  logic [3:0] pins;

  // register file state
  logic [7:0] tctl_r, tctl_nxt;
  logic [7:0] rctl_r, rctl_nxt;
  logic [7:0] lctl_r, lctl_nxt;
  logic [15:0] baud_divisor_r, baud_divisor_nxt;
  logic [7:0] rx_buffer_r, rx_buffer_nxt;
  logic rx_interrupt_flag_r, rx_interrupt_flag_nxt;
  logic [7:0] tx_buffer_r, tx_buffer_nxt;
  logic tx_buf_full_r, tx_buf_full_nxt;
  // bus answer state
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  // transmit shifter state
  uart_pkg::tx_state_t tx_st_r, tx_st_nxt;
  logic [12:0] tx_frame_r, tx_frame_nxt;
  logic [3:0] tx_left_r, tx_left_nxt;
  logic txd_r, txd_nxt;
  // start-edge detect state
  logic rxd_prev_r, rx_edge_r, rx_edge_nxt;

  logic wr_commit, rd_commit;
  uart_pkg::reg_sel_t sel;
  logic ch_err, ch_take;
  logic [12:0] frame;
  logic [3:0] flen, pos;
  logic [7:0] tdata;

  uart_core_if core ();

  // the shared address decode used by both the read mux and the write path
  function automatic uart_pkg::reg_sel_t decode_reg(input logic [7:0] a);
    uart_pkg::reg_sel_t s;
    s = uart_pkg::SEL_NONE;
    if (a == `UART_OFS_TCTL) begin
      s = uart_pkg::SEL_TCTL;
    end else if (a == `UART_OFS_RCTL) begin
      s = uart_pkg::SEL_RCTL;
    end else if (a == `UART_OFS_BRLO) begin
      s = uart_pkg::SEL_BRLO;
    end else if (a == `UART_OFS_BRHI) begin
      s = uart_pkg::SEL_BRHI;
    end else if (a == `UART_OFS_LCTL) begin
      s = uart_pkg::SEL_LCTL;
    end else if (a == `UART_OFS_TXBUF) begin
      s = uart_pkg::SEL_TXBUF;
    end else if (a == `UART_OFS_RXBUF) begin
      s = uart_pkg::SEL_RXBUF;
    end else if (a == `UART_OFS_STAT) begin
      s = uart_pkg::SEL_STAT;
    end
    return s;
  endfunction : decode_reg

  // reset release through two flops
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // two-flop synchronisers for the pins and foreign clocks
  assign pins = {rxd_i, submain_clock_i, aux_clock_i, external_bitclock_pin_i};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta_r[gi] <= 1'b1;
          pin_sync_r[gi] <= 1'b1;
        end else begin
          pin_meta_r[gi] <= pins[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
        end
      end
    end
  endgenerate

  // configuration handed to the baud generator and receiver
  assign core.pin_clk = pin_sync_r[0];
  assign core.aux_clk = pin_sync_r[1];
  assign core.sub_clk = pin_sync_r[2];
  assign core.rxd = pin_sync_r[3];
  assign core.pol_invert = tctl_r[`UART_TCTL_POL];
  assign core.src_sel = tctl_r[`UART_TCTL_SSEL_HI:`UART_TCTL_SSEL_LO];
  assign core.divisor = baud_divisor_r;
  assign core.char8 = lctl_r[`UART_LCTL_CHAR8];
  assign core.addr_bit_en = lctl_r[`UART_LCTL_ADDRBIT];
  assign core.parity_en = lctl_r[`UART_LCTL_PARITY_ENABLE];
  assign core.parity_even = lctl_r[`UART_LCTL_PEVEN];

  uart_baud_gen u_baud (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .core(core.baud)
  );

  uart_rx_frame u_rx (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .core(core.rx)
  );

  // build the outgoing frame, lsb first: start, data, address bit, parity, stop
  always_comb begin
    tdata = lctl_r[`UART_LCTL_CHAR8] ? tx_buffer_r : {1'b0, tx_buffer_r[6:0]};
    frame = 13'h1FFF;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < (lctl_r[`UART_LCTL_CHAR8] ? 8 : 7)) begin
        frame[i + 1] = tdata[i];
      end
    end
    pos = lctl_r[`UART_LCTL_CHAR8] ? 4'h9 : 4'h8;
    if (lctl_r[`UART_LCTL_ADDRBIT]) begin
      frame[pos] = tctl_r[`UART_TCTL_WAKE];
      pos = pos + 4'h1;
    end
    if (lctl_r[`UART_LCTL_PARITY_ENABLE]) begin
      // parity select only matters here, with parity on
      frame[pos] = (^tdata) ^ (lctl_r[`UART_LCTL_ADDRBIT] & tctl_r[`UART_TCTL_WAKE])
                   ^ ~lctl_r[`UART_LCTL_PEVEN];
      pos = pos + 4'h1;
    end
    flen = pos + 4'h1 + {3'h0, lctl_r[`UART_LCTL_STOP2]};
  end

  // apb: one wait state, so prdata and pready come from flops
  always_comb begin
    sel = decode_reg(paddr_i);
    wr_commit = psel_i & penable_i & pready_r & pwrite_i;
    rd_commit = psel_i & penable_i & pready_r & ~pwrite_i;
    pready_nxt = psel_i & penable_i & ~pready_r;
    pslverr_nxt = pready_nxt & (sel == uart_pkg::SEL_NONE);
    prdata_nxt = 32'h0000_0000;
    if (pready_nxt & ~pwrite_i) begin
      if (sel == uart_pkg::SEL_TCTL) begin
        prdata_nxt[7:0] = {1'b0, tctl_r[6:2], 1'b0, ~tx_buf_full_r & (tx_st_r == uart_pkg::TX_IDLE)};
      end else if (sel == uart_pkg::SEL_RCTL) begin
        prdata_nxt[7:0] = rctl_r;
        prdata_nxt[`UART_RCTL_PE] = rctl_r[`UART_RCTL_PE] & lctl_r[`UART_LCTL_PARITY_ENABLE];
      end else if (sel == uart_pkg::SEL_BRLO) begin
        prdata_nxt[7:0] = baud_divisor_r[7:0];
      end else if (sel == uart_pkg::SEL_BRHI) begin
        prdata_nxt[7:0] = baud_divisor_r[15:8];
      end else if (sel == uart_pkg::SEL_LCTL) begin
        prdata_nxt[7:0] = lctl_r;
      end else if (sel == uart_pkg::SEL_TXBUF) begin
        prdata_nxt[7:0] = tx_buffer_r;
      end else if (sel == uart_pkg::SEL_RXBUF) begin
        prdata_nxt[7:0] = rx_buffer_r;
      end else if (sel == uart_pkg::SEL_STAT) begin
        prdata_nxt[`UART_STAT_RXIFG] = rx_interrupt_flag_r;
        prdata_nxt[`UART_STAT_TXBUF_FREE] = ~tx_buf_full_r;
      end
    end
  end

  // registers, receive flags and the transmitter
  always_comb begin
    tctl_nxt = tctl_r;
    rctl_nxt = rctl_r;
    lctl_nxt = lctl_r;
    baud_divisor_nxt = baud_divisor_r;
    rx_buffer_nxt = rx_buffer_r;
    rx_interrupt_flag_nxt = rx_interrupt_flag_r;
    tx_buffer_nxt = tx_buffer_r;
    tx_buf_full_nxt = tx_buf_full_r;
    tx_st_nxt = tx_st_r;
    tx_frame_nxt = tx_frame_r;
    tx_left_nxt = tx_left_r;
    txd_nxt = txd_r;
    rx_edge_nxt = tctl_r[`UART_TCTL_RXSE] & rxd_prev_r & ~core.rxd;
    // software side first, so hardware sets below win over a clear
    if (wr_commit) begin
      if (sel == uart_pkg::SEL_TCTL) begin
        tctl_nxt[6:2] = pwdata_i[6:2]; // empty flag not writable
      end else if (sel == uart_pkg::SEL_RCTL) begin
        rctl_nxt[`UART_RCTL_EIE] = pwdata_i[`UART_RCTL_EIE];
        rctl_nxt[`UART_RCTL_WIE] = pwdata_i[`UART_RCTL_WIE];
      end else if (sel == uart_pkg::SEL_BRLO) begin
        baud_divisor_nxt[7:0] = pwdata_i[7:0];
      end else if (sel == uart_pkg::SEL_BRHI) begin
        baud_divisor_nxt[15:8] = pwdata_i[7:0];
      end else if (sel == uart_pkg::SEL_LCTL) begin
        lctl_nxt = {pwdata_i[7:4], 2'h0, pwdata_i[1], 1'b0};
      end else if (sel == uart_pkg::SEL_TXBUF) begin
        tx_buffer_nxt = pwdata_i[7:0];
        tx_buf_full_nxt = 1'b1;
      end
    end
    if (rd_commit & (sel == uart_pkg::SEL_RXBUF)) begin
      rctl_nxt = rctl_r & 8'h0C;
      rx_interrupt_flag_nxt = 1'b0;
    end
    // a character from the receiver
    ch_err = core.ch_frame_err | (core.ch_parity_err & lctl_r[`UART_LCTL_PARITY_ENABLE]) | core.ch_break;
    ch_take = (~ch_err | rctl_r[`UART_RCTL_EIE])
              & (~rctl_r[`UART_RCTL_WIE] | core.ch_addr);
    if (core.ch_valid) begin
      if (core.ch_frame_err) begin
        rctl_nxt[`UART_RCTL_FE] = 1'b1;
      end
      if (core.ch_parity_err & lctl_r[`UART_LCTL_PARITY_ENABLE]) begin
        rctl_nxt[`UART_RCTL_PE] = 1'b1;
      end
      if (core.ch_break) begin
        rctl_nxt[`UART_RCTL_BRK] = 1'b1;
      end
      if (ch_take) begin
        rx_buffer_nxt = core.ch_data;
        rx_interrupt_flag_nxt = 1'b1;
        rctl_nxt[`UART_RCTL_WAKE] = core.ch_addr;
        // unread previous character still pending, and not being read now
        if (rx_interrupt_flag_r & ~(rd_commit & (sel == uart_pkg::SEL_RXBUF))) begin
          rctl_nxt[`UART_RCTL_OE] = 1'b1;
        end
      end
    end
    rctl_nxt[`UART_RCTL_ERR] = |rctl_nxt[7:4];
    // transmitter: load from buffer when idle, shift one bit per bit tick
    case (tx_st_r)
      uart_pkg::TX_IDLE: begin
        txd_nxt = 1'b1;
        if (tx_buf_full_r) begin
          tx_frame_nxt = frame;
          tx_left_nxt = flen;
          tx_buf_full_nxt = wr_commit & (sel == uart_pkg::SEL_TXBUF);
          tctl_nxt[`UART_TCTL_WAKE] = 1'b0; // wake applies to one frame only
          tx_st_nxt = uart_pkg::TX_SHIFT;
        end
      end
      default: begin
        if (core.bit_tick) begin
          if (tx_left_r == 4'h0) begin
            txd_nxt = 1'b1;
            tx_st_nxt = uart_pkg::TX_IDLE;
          end else begin
            txd_nxt = tx_frame_r[0];
            tx_frame_nxt = {1'b1, tx_frame_r[12:1]};
            tx_left_nxt = tx_left_r - 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      tctl_r <= `UART_TCTL_RESET;
      rctl_r <= `UART_RCTL_RESET;
      lctl_r <= `UART_LCTL_RESET;
      baud_divisor_r <= `UART_BR_RESET;
      rx_buffer_r <= 8'h00;
      rx_interrupt_flag_r <= 1'b0;
      tx_buffer_r <= 8'h00;
      tx_buf_full_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      tx_st_r <= uart_pkg::TX_IDLE;
      tx_frame_r <= 13'h1FFF;
      tx_left_r <= 4'h0;
      txd_r <= 1'b1;
      rxd_prev_r <= 1'b1;
      rx_edge_r <= 1'b0;
    end else begin
      tctl_r <= tctl_nxt;
      rctl_r <= rctl_nxt;
      lctl_r <= lctl_nxt;
      baud_divisor_r <= baud_divisor_nxt;
      rx_buffer_r <= rx_buffer_nxt;
      rx_interrupt_flag_r <= rx_interrupt_flag_nxt;
      tx_buffer_r <= tx_buffer_nxt;
      tx_buf_full_r <= tx_buf_full_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      tx_st_r <= tx_st_nxt;
      tx_frame_r <= tx_frame_nxt;
      tx_left_r <= tx_left_nxt;
      txd_r <= txd_nxt;
      rxd_prev_r <= core.rxd;
      rx_edge_r <= rx_edge_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign txd_o = txd_r;
  assign rx_start_edge_o = rx_edge_r;
endmodule : uart_ctrl_top

// [verilog/uart_rx_frame.sv]
`timescale 1ns/1ps

module uart_rx_frame (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  uart_core_if.rx core
);
  uart_pkg::rx_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [9:0] bits_r, bits_nxt;
  logic valid_r, valid_nxt;
  logic fe_r, fe_nxt;
  logic pe_r, pe_nxt;
  logic brk_r, brk_nxt;
  logic [3:0] nd, nbits;
  logic [7:0] data;
  logic addr, par, exp_par;

  always_comb begin
    nd = core.char8 ? 4'h8 : 4'h7;
    nbits = nd + {3'h0, core.addr_bit_en} + {3'h0, core.parity_en};
    data = core.char8 ? bits_r[7:0] : {1'b0, bits_r[6:0]};
    addr = core.addr_bit_en & bits_r[nd];
    par = bits_r[nd + {3'h0, core.addr_bit_en}];
    // even setting: total of ones including parity is even
    exp_par = (^data) ^ addr ^ ~core.parity_even;
  end

  // sample in mid bit, one divisor of source ticks per bit
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    bits_nxt = bits_r;
    valid_nxt = 1'b0;
    fe_nxt = fe_r;
    pe_nxt = pe_r;
    brk_nxt = brk_r;
    case (st_r)
      uart_pkg::RX_IDLE: begin
        if (!core.rxd) begin
          st_nxt = uart_pkg::RX_START;
          cnt_nxt = {1'b0, core.divisor[15:1]};
        end
      end
      uart_pkg::RX_START: begin
        if (core.src_tick) begin
          if (cnt_r != 16'h0000) begin
            cnt_nxt = cnt_r - 16'h0001;
          end else if (core.rxd) begin
            st_nxt = uart_pkg::RX_IDLE; // glitch, not a start bit
          end else begin
            st_nxt = uart_pkg::RX_BITS;
            cnt_nxt = core.divisor - 16'h0001;
            idx_nxt = 4'h0;
            bits_nxt = 10'h000;
          end
        end
      end
      uart_pkg::RX_BITS: begin
        if (core.src_tick) begin
          if (cnt_r != 16'h0000) begin
            cnt_nxt = cnt_r - 16'h0001;
          end else begin
            bits_nxt[idx_r] = core.rxd;
            idx_nxt = idx_r + 4'h1;
            cnt_nxt = core.divisor - 16'h0001;
            if (idx_r + 4'h1 == nbits) begin
              st_nxt = uart_pkg::RX_STOP;
            end
          end
        end
      end
      default: begin
        if (core.src_tick) begin
          if (cnt_r != 16'h0000) begin
            cnt_nxt = cnt_r - 16'h0001;
          end else begin
            st_nxt = uart_pkg::RX_IDLE;
            valid_nxt = 1'b1;
            fe_nxt = ~core.rxd;
            pe_nxt = core.parity_en & (par != exp_par);
            brk_nxt = ~core.rxd & (bits_r == 10'h000);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= uart_pkg::RX_IDLE;
      cnt_r <= 16'h0000;
      idx_r <= 4'h0;
      bits_r <= 10'h000;
      valid_r <= 1'b0;
      fe_r <= 1'b0;
      pe_r <= 1'b0;
      brk_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      bits_r <= bits_nxt;
      valid_r <= valid_nxt;
      fe_r <= fe_nxt;
      pe_r <= pe_nxt;
      brk_r <= brk_nxt;
    end
  end

  assign core.ch_valid = valid_r;
  assign core.ch_data = data;
  assign core.ch_addr = addr;
  assign core.ch_frame_err = fe_r;
  assign core.ch_parity_err = pe_r;
  assign core.ch_break = brk_r;
endmodule : uart_rx_frame
